// >>> rtl/prs_pin_route.v
// Purpose: Routes peripheral signal groups onto port pins over GPIO
// Assumes: Peripheral enables are synchronous to i_sys_clk; pins are not
// Notes:   Pins and oe are registered, one cycle late; returned inputs are three cycles late
`timescale 1ns/1ps
`include "prs_defs.vh"

module prs_pin_route
(
  // Clock and reset
  input  wire        i_sys_clk,
  input  wire        i_rst_n,
  // Avalon-MM slave, word addressed
  input  wire [2:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [3:0]  i_avs_byteenable,
  input  wire [31:0] i_avs_writedata,
  output reg  [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // General-purpose port logic, bit P*8+n is pin n of port P
  input  wire [47:0] i_gpio_out,
  input  wire [47:0] i_gpio_oe,
  output reg  [47:0] o_gpio_in,
  // Pads
  input  wire [47:0] i_pin_in,
  output reg  [47:0] o_pin_out,
  output reg  [47:0] o_pin_oe,
  // Serial port zero
  input  wire        i_ser0_en,
  input  wire [3:0]  i_ser0_out,
  input  wire [3:0]  i_ser0_oe,
  output reg  [3:0]  o_ser0_in,
  // Serial port one
  input  wire        i_ser1_en,
  input  wire [3:0]  i_ser1_out,
  input  wire [3:0]  i_ser1_oe,
  output reg  [3:0]  o_ser1_in,
  // Two-wire main pins, bit 1 clock, bit 0 data
  input  wire        i_tw_en,
  input  wire [1:0]  i_tw_out,
  input  wire [1:0]  i_tw_oe,
  output reg  [1:0]  o_tw_in,
  // Two-wire dual-mode slave pins
  input  wire        i_tw_dual_en,
  input  wire [1:0]  i_tws_out,
  input  wire [1:0]  i_tws_oe,
  output reg  [1:0]  o_tws_in,
  // SPI port
  input  wire        i_spi_en,
  input  wire [3:0]  i_spi_out,
  input  wire [3:0]  i_spi_oe,
  output reg  [3:0]  o_spi_in,
  // Timer A waveform outputs
  input  wire        i_tca_en,
  input  wire [5:0]  i_tca_out,
  // Timer B outputs, bit k is timer k
  input  wire [3:0]  i_tcb_en,
  input  wire [3:0]  i_tcb_out
);

  // Reset synchroniser and pad input synchroniser
  reg        rst_s1_q;
  reg        rst_n_q;
  reg [47:0] pin_s1_q;
  reg [47:0] pin_s2_q;
  // Route registers
  reg [7:0]  serial_route_q;
  reg [7:0]  two_wire_and_spi_route_q;
  reg [7:0]  timer_a_route_q;
  reg [7:0]  timer_b_route_q;
  // Bus handshake
  reg        ack_q;
  wire       req;
  wire       wr_take;
  wire [7:0] wr_byte;
  reg  [7:0] rd_d;
  // Combinational pin map
  reg [47:0] out_d;
  reg [47:0] oe_d;
  reg [47:0] gpio_in_d;
  reg [3:0]  ser0_in_d;
  reg [3:0]  ser1_in_d;
  reg [1:0]  tw_in_d;
  reg [1:0]  tws_in_d;
  reg [3:0]  spi_in_d;
  integer    b;
  integer    k;

  // Map a two-bit route code to a pin base, -1 for unconnected
  function integer sel_base;
    input [1:0] code;
    input integer b0;
    input integer b1;
    input integer b2;
    begin
      case (code)
        2'h0:    sel_base = b0;
        2'h1:    sel_base = b1;
        2'h2:    sel_base = b2;
        default: sel_base = `PRS_NONE;
      endcase
    end
  endfunction

  // Reset released through two flops, asserted at once
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Pads are asynchronous, so they pass two flops before use
  always @(posedge i_sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pin_s1_q <= 48'h0;
      pin_s2_q <= 48'h0;
    end
    else
    begin
      pin_s1_q <= i_pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // One wait cycle per access keeps read data registered
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_q;
  assign wr_take           = i_avs_write & ack_q & i_avs_byteenable[0];
  assign wr_byte           = i_avs_writedata[7:0];

  // Read decode, unmapped indices read zero
  always @*
  begin
    case (i_avs_address)
      `PRS_IDX_SERIAL:  rd_d = serial_route_q;
      `PRS_IDX_TWS:     rd_d = two_wire_and_spi_route_q;
      `PRS_IDX_TIMER_A: rd_d = timer_a_route_q;
      `PRS_IDX_TIMER_B: rd_d = timer_b_route_q;
      default:          rd_d = 8'h00;
    endcase
  end

  // Register file; reserved codes are stored and read back as written
  always @(posedge i_sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ack_q                    <= 1'b0;
      o_avs_readdata           <= 32'h0;
      serial_route_q           <= `PRS_RESET_VALUE;
      two_wire_and_spi_route_q <= `PRS_RESET_VALUE;
      timer_a_route_q          <= `PRS_RESET_VALUE;
      timer_b_route_q          <= `PRS_RESET_VALUE;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (i_avs_read && !ack_q)
        o_avs_readdata <= {24'h0, rd_d};
      if (wr_take)
      begin
        case (i_avs_address)
          `PRS_IDX_SERIAL:
            serial_route_q <= wr_byte & `PRS_MASK_SERIAL;
          `PRS_IDX_TWS:
            two_wire_and_spi_route_q <= wr_byte & `PRS_MASK_TWS;
          `PRS_IDX_TIMER_A:
            timer_a_route_q <= wr_byte & `PRS_MASK_TIMER_A;
          `PRS_IDX_TIMER_B:
            timer_b_route_q <= wr_byte & `PRS_MASK_TIMER_B;
          default:
            ;
        endcase
      end
    end
  end

  // Pin map: GPIO first, then each enabled peripheral on top.
  // Later groups win where two routes share a pin, so software
  // must avoid overlapping choices.
  always @*
  begin
    out_d     = i_gpio_out;
    oe_d      = i_gpio_oe;
    gpio_in_d = pin_s2_q;
    ser0_in_d = 4'h0;
    ser1_in_d = 4'h0;
    tw_in_d   = 2'h0;
    tws_in_d  = 2'h0;
    spi_in_d  = 4'h0;
    // Timer A: six outputs on one port, reserved codes go nowhere
    if (i_tca_en && timer_a_route_q[2:0] <= `PRS_TCA_LAST_CODE)
    begin
      b = timer_a_route_q[2:0] * `PRS_PORT_WIDTH;
      for (k = 0; k < 6; k = k + 1)
      begin
        out_d[b + k] = i_tca_out[k];
        oe_d[b + k]  = 1'b1;
      end
    end
    // Timer B outputs, one pin each
    for (k = 0; k < 4; k = k + 1)
    begin
      case (k)
        0: b = timer_b_route_q[0] ? `PRS_PF4 : `PRS_PA2;
        1: b = timer_b_route_q[1] ? `PRS_PF5 : `PRS_PA3;
        2: b = timer_b_route_q[2] ? `PRS_PB4 : `PRS_PC0;
        default: b = timer_b_route_q[3] ? `PRS_PC1 : `PRS_PB5;
      endcase
      if (i_tcb_en[k])
      begin
        out_d[b] = i_tcb_out[k];
        oe_d[b]  = 1'b1;
      end
    end
    // Serial port zero
    b = sel_base(serial_route_q[`PRS_SER0_LSB +: 2],
                 `PRS_PA0, `PRS_PA4, `PRS_NONE);
    if (i_ser0_en && b >= 0)
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        out_d[b + k] = i_ser0_out[k];
        oe_d[b + k]  = i_ser0_oe[k];
        ser0_in_d[k] = pin_s2_q[b + k];
      end
    end
    // Serial port one
    b = sel_base(serial_route_q[`PRS_SER1_LSB +: 2],
                 `PRS_PC0, `PRS_PC4, `PRS_NONE);
    if (i_ser1_en && b >= 0)
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        out_d[b + k] = i_ser1_out[k];
        oe_d[b + k]  = i_ser1_oe[k];
        ser1_in_d[k] = pin_s2_q[b + k];
      end
    end
    // Two-wire main pins; code 3 is reserved and connects nothing
    b = sel_base(two_wire_and_spi_route_q[`PRS_TW_LSB +: 2],
                 `PRS_PA2, `PRS_PA2, `PRS_PC2);
    if (i_tw_en && b >= 0)
    begin
      for (k = 0; k < 2; k = k + 1)
      begin
        out_d[b + k] = i_tw_out[k];
        oe_d[b + k]  = i_tw_oe[k];
        tw_in_d[k]   = pin_s2_q[b + k];
      end
    end
    // Two-wire dual-mode slave pins
    b = sel_base(two_wire_and_spi_route_q[`PRS_TW_LSB +: 2],
                 `PRS_PC2, `PRS_PF2, `PRS_PF2);
    if (i_tw_en && i_tw_dual_en && b >= 0)
    begin
      for (k = 0; k < 2; k = k + 1)
      begin
        out_d[b + k] = i_tws_out[k];
        oe_d[b + k]  = i_tws_oe[k];
        tws_in_d[k]  = pin_s2_q[b + k];
      end
    end
    // SPI port
    b = sel_base(two_wire_and_spi_route_q[`PRS_SPI_LSB +: 2],
                 `PRS_PA4, `PRS_PC0, `PRS_PE0);
    if (i_spi_en && b >= 0)
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        out_d[b + k] = i_spi_out[k];
        oe_d[b + k]  = i_spi_oe[k];
        spi_in_d[k]  = pin_s2_q[b + k];
      end
    end
  end

  // Registered pad drive and returned inputs; pads float in reset
  always @(posedge i_sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      o_pin_out <= 48'h0;
      o_pin_oe  <= 48'h0;
      o_gpio_in <= 48'h0;
      o_ser0_in <= 4'h0;
      o_ser1_in <= 4'h0;
      o_tw_in   <= 2'h0;
      o_tws_in  <= 2'h0;
      o_spi_in  <= 4'h0;
    end
    else
    begin
      o_pin_out <= out_d;
      o_pin_oe  <= oe_d;
      o_gpio_in <= gpio_in_d;
      o_ser0_in <= ser0_in_d;
      o_ser1_in <= ser1_in_d;
      o_tw_in   <= tw_in_d;
      o_tws_in  <= tws_in_d;
      o_spi_in  <= spi_in_d;
    end
  end

endmodule

// >>> rtl/prs_defs.vh
// Purpose: Constants for the peripheral pin route selector
// Assumes: Registers are reached by word index over Avalon-MM
// Notes:   Pin index of port P bit n is P*8+n, ports A..F are 0..5
`ifndef PRS_DEFS_VH
`define PRS_DEFS_VH

// Register word indices
`define PRS_IDX_SERIAL    3'h2
`define PRS_IDX_TWS       3'h3
`define PRS_IDX_TIMER_A   3'h4
`define PRS_IDX_TIMER_B   3'h5

// Implemented bits of each register, the rest read as zero
`define PRS_MASK_SERIAL   8'h0f
`define PRS_MASK_TWS      8'h33
`define PRS_MASK_TIMER_A  8'h07
`define PRS_MASK_TIMER_B  8'h0f
`define PRS_RESET_VALUE   8'h00

// Field positions
`define PRS_SER0_LSB      0
`define PRS_SER1_LSB      2
`define PRS_SPI_LSB       0
`define PRS_TW_LSB        4
`define PRS_TCA_LAST_CODE 3'h5

// Pin bases (port*8 + pin), -1 means not connected
`define PRS_NONE          -1
`define PRS_PA0           0
`define PRS_PA2           2
`define PRS_PA3           3
`define PRS_PA4           4
`define PRS_PB4           12
`define PRS_PB5           13
`define PRS_PC0           16
`define PRS_PC1           17
`define PRS_PC2           18
`define PRS_PC4           20
`define PRS_PE0           32
`define PRS_PF2           42
`define PRS_PF4           44
`define PRS_PF5           45
`define PRS_PORT_WIDTH    8
`define PRS_NUM_PINS      48

`endif

// >>> tb/prs_periph_model.sv
// Purpose: Stand-in for peripherals and pads of the pin route selector
// Assumes: One clock, enables come from the bench
// Notes:   Released pads show a pattern that shifts by one bit every cycle
`timescale 1ns/1ps
module prs_periph_model
(
  // Clock
  input  wire        i_clk,
  // Pad drive from the block
  input  wire [47:0] i_pout,
  input  wire [47:0] i_poe,
  // Peripheral pattern and pad level
  output logic [31:0] o_pat,
  output logic [47:0] o_pad
);
  // Pattern moves at every rising edge so each sample is fresh
  initial o_pat = 32'h1;
  always @(posedge i_clk)
    o_pat <= {o_pat[30:0], o_pat[31] ^ o_pat[21] ^ o_pat[1] ^ o_pat[0]};
  // Undriven pads show the inverse of a moving pattern
  assign o_pad = (i_poe & i_pout) | (~i_poe & ~{o_pat[15:0], o_pat});
endmodule

// >>> tb/prs_pin_route_assertions.sv
// Purpose: Port checks for the pin route selector
// Assumes: Sees only top ports, mirrors two route registers
// Notes:   Internal reset lags two edges, age counter covers it
`timescale 1ns/1ps
module prs_pin_route_assertions
(
  // Clock and reset
  input wire        i_sys_clk,
  input wire        i_rst_n,
  // Register bus
  input wire [2:0]  i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [3:0]  i_avs_byteenable,
  input wire [31:0] i_avs_writedata,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  // Pins and timers
  input wire [47:0] i_gpio_out,
  input wire [47:0] i_gpio_oe,
  input wire [47:0] o_gpio_in,
  input wire [47:0] i_pin_in,
  input wire [47:0] o_pin_out,
  input wire [47:0] o_pin_oe,
  input wire        i_tca_en,
  input wire [5:0]  i_tca_out,
  input wire [3:0]  i_tcb_en,
  input wire [3:0]  i_tcb_out
);
  logic [3:0] tb_q;
  logic [2:0] ta_q;
  logic [2:0] age_q;
  wire wr_w = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // Mirror routes; age hides the pipeline still flushing after reset
  always @(posedge i_sys_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      tb_q <= 4'h0;
      ta_q <= 3'h0;
      age_q <= 3'h0;
    end
    else
    begin
      age_q <= age_q + {2'h0, age_q != 3'h7};
      if (wr_w && i_avs_address == 3'h5) tb_q <= i_avs_writedata[3:0];
      if (wr_w && i_avs_address == 3'h4) ta_q <= i_avs_writedata[2:0];
    end
  AST_WAIT_ONE: assert property (
    (i_avs_read | i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("wait longer than one cycle");
  AST_WAIT_RISE: assert property ($rose(i_avs_read) |-> o_avs_waitrequest)
    else $error("read answered at once");
  AST_RD_TB: assert property (
    i_avs_read && !o_avs_waitrequest && i_avs_address == 3'h5
    |-> o_avs_readdata == {28'h0, tb_q}) else $error("timer b readback");
  AST_TMRB_ZERO_ALT: assert property (
    $past(i_tcb_en[0] & tb_q[0]) |-> o_pin_oe[44]
    && o_pin_out[44] == $past(i_tcb_out[0])) else $error("timer b0 alt");
  AST_TMRB_THREE_DEF: assert property (
    i_tcb_en[3] && !tb_q[3] ##1 1'b1 |-> o_pin_oe[13]
    && o_pin_out[13] == $past(i_tcb_out[3])) else $error("timer b3 pin");
  AST_TCA_D: assert property (
    $past(i_tca_en) && $past(ta_q) == 3'h3 |-> &o_pin_oe[29:24]
    && o_pin_out[29:24] == $past(i_tca_out)) else $error("timer a port d");
  AST_GPIO_OUT: assert property (age_q == 3'h7 |=>
    o_pin_out[30] == $past(i_gpio_out[30])
    && o_pin_oe[30] == $past(i_gpio_oe[30])) else $error("gpio drive");
  AST_GPIO_IN: assert property (age_q == 3'h7 |->
    o_gpio_in[30] == $past(i_pin_in[30], 3)) else $error("gpio input");
  // Main scenarios
  C_WR_TB: cover property (wr_w && i_avs_address == 3'h5);
  C_TCA_D: cover property (i_tca_en && ta_q == 3'h3);
  C_TMRB_ZERO: cover property (i_tcb_en[0] && tb_q[0]);
endmodule
bind prs_pin_route prs_pin_route_assertions i_chk (.*);

// >>> tb/prs_pin_route_tb.sv
// Purpose: Self-checking bench for the pin route selector
// Assumes: Word-indexed registers, one wait cycle per access
// Notes:   Reads are scored through a queue, pins one cycle late
`timescale 1ns/1ps
module prs_pin_route_tb;
  logic i_sys_clk = 1'h0, i_rst_n = 1'h0, i_avs_read = 1'h0;
  logic i_avs_write = 1'h0, i_tca_en = 1'h0, i_ser0_en = 1'h0;
  logic i_ser1_en = 1'h0, i_tw_en = 1'h0, i_tw_dual_en = 1'h0;
  logic i_spi_en = 1'h0, o_avs_waitrequest;
  logic [2:0] i_avs_address = 3'h0;
  logic [3:0] i_avs_byteenable = 4'h0, i_tcb_en = 4'h0;
  logic [3:0] o_ser0_in, o_ser1_in, o_spi_in;
  logic [1:0] o_tw_in, o_tws_in;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, pat;
  logic [47:0] i_gpio_out = 48'h0, i_gpio_oe = 48'h0;
  logic [47:0] o_gpio_in, i_pin_in, o_pin_out, o_pin_oe;
  wire [3:0] i_ser0_out = pat[3:0], i_ser0_oe = pat[7:4];
  wire [3:0] i_ser1_out = pat[11:8], i_ser1_oe = pat[15:12];
  wire [1:0] i_tw_out = pat[17:16], i_tw_oe = pat[19:18];
  wire [1:0] i_tws_out = pat[21:20], i_tws_oe = pat[23:22];
  wire [3:0] i_spi_out = pat[27:24], i_spi_oe = pat[31:28];
  wire [5:0] i_tca_out = pat[9:4];
  wire [3:0] i_tcb_out = pat[13:10];
  logic [7:0] q[$];
  logic [7:0] v;
  logic [47:0] pad1, pad2, pad3;
  int n_mismatch = 0, tests_run = 0, p0[4] = '{2, 3, 16, 13};
  int p1[4] = '{44, 45, 12, 17};
  prs_pin_route i_prs_pin_route (.*);
  prs_periph_model i_prs_periph_model (.i_clk(i_sys_clk),
    .i_pout(o_pin_out), .i_poe(o_pin_oe), .o_pat(pat), .o_pad(i_pin_in));
  always #5 i_sys_clk = ~i_sys_clk;
  // Random GPIO drive keeps passthrough pins busy
  always @(posedge i_sys_clk)
    {i_gpio_out, i_gpio_oe} <= {$urandom, $urandom, $urandom};
  // Pad history lines up with the three-edge input return path
  always @(posedge i_sys_clk)
    {pad3, pad2, pad1} <= {pad2, pad1, i_pin_in};
  task automatic note(input bit ok);
    tests_run++;
    if (!ok) n_mismatch++;
    if (!ok) $display("mismatch %0t compare failed", $time);
  endtask
  task automatic cmp_rd(input logic [31:0] g, input logic [7:0] e);
    note(g === {24'h0, e});
  endtask
  task automatic cmp_pin(input logic [1:0] g, input logic [1:0] e);
    note(g === e);
  endtask
  task automatic cmp_in(input logic [7:0] g, input logic [7:0] e);
    note(g === e);
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input bit w, input int a, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge i_sys_clk);
    i_avs_address <= a[2:0];
    i_avs_writedata <= {24'h0, d};
    i_avs_byteenable <= be;
    i_avs_write <= w;
    i_avs_read <= !w;
    do
      @(posedge i_sys_clk);
    while (o_avs_waitrequest !== 1'h0);
    i_avs_write <= 1'h0;
    i_avs_read <= 1'h0;
  endtask
  task automatic rd(input int a, input logic [7:0] e);
    q.push_back(e);
    bus(0, a, 8'h0, 4'h1);
  endtask
  // Read data are scored at the completing edge
  always @(posedge i_sys_clk)
    if (i_avs_read && o_avs_waitrequest === 1'h0)
      cmp_rd(o_avs_readdata, q.pop_front());
  function automatic logic [15:0] src(input int k, input int b);
    case (k)
      0: return {4'h0, i_ser0_oe, 4'h0, i_ser0_out};
      1: return {4'h0, i_ser1_oe, 4'h0, i_ser1_out};
      2: return {6'h0, i_tw_oe, 6'h0, i_tw_out};
      3: return {6'h0, i_tws_oe, 6'h0, i_tws_out};
      4: return {4'h0, i_spi_oe, 4'h0, i_spi_out};
      5: return {8'h3f, 2'h0, i_tca_out};
      6: return {8'h01, 7'h0, i_tcb_out[b]};
      default: return {i_gpio_oe[b+:8], i_gpio_out[b+:8]};
    endcase
  endfunction
  // Sources sampled at one edge must show on the pins after the next
  task automatic probe(input int k, input int b, input int n, input int t);
    logic [15:0] s;
    logic [7:0] g, m;
    @(posedge i_sys_clk);
    #1;
    s = src(k, t);
    @(posedge i_sys_clk);
    #1;
    for (int i = 0; i < n; i++)
      cmp_pin({o_pin_oe[b+i], o_pin_out[b+i]}, {s[8+i], s[i]});
    // Returned inputs show the pad level of three edges back
    m = 8'((1 << n) - 1);
    g = k == 0 ? {4'h0, o_ser0_in} : k == 1 ? {4'h0, o_ser1_in}
      : k == 2 ? {6'h0, o_tw_in} : k == 3 ? {6'h0, o_tws_in}
      : k == 4 ? {4'h0, o_spi_in} : o_gpio_in[b +: 8];
    cmp_in(g & m, pad3[b +: 8] & m);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'ha25dd86e));
    repeat (12) @(posedge i_sys_clk);
    i_rst_n <= 1'h1;
    repeat (3) @(posedge i_sys_clk);
    for (int a = 0; a < 8; a++) rd(a, 8'h0);
    for (int a = 0; a < 8; a++)
    begin
      v = $urandom;
      bus(1, a, v, 4'h1);
      bus(1, a, ~v, 4'h0);
      rd(a, v & (a == 3 ? 8'h33 : a == 4 ? 8'h07 : a == 2 || a == 5 ? 8'h0f
             : 8'h00));
    end
    $display("test registers done");
    {i_ser0_en, i_ser1_en} <= 2'h3;
    for (int c = 0; c < 2; c++)
    begin
      bus(1, 2, 8'(c * 5), 4'h1);
      probe(0, c * 4, 4, 0);
      probe(1, 16 + c * 4, 4, 0);
    end
    bus(1, 2, 8'h0f, 4'h1);
    probe(7, 0, 8, 0);
    probe(7, 16, 8, 16);
    {i_ser0_en, i_ser1_en, i_tw_en, i_tw_dual_en} <= 4'h3;
    for (int c = 0; c < 3; c++)
    begin
      bus(1, 3, 8'(c * 16), 4'h1);
      probe(2, c == 2 ? 18 : 2, 2, 0);
      probe(3, c == 0 ? 18 : 42, 2, 0);
    end
    {i_tw_en, i_tw_dual_en, i_spi_en} <= 3'h1;
    for (int c = 0; c < 4; c++)
    begin
      bus(1, 3, 8'(c), 4'h1);
      probe(c == 3 ? 7 : 4, c == 0 ? 4 : c == 1 ? 16 : 32, 4,
            c == 3 ? 32 : 0);
    end
    $display("test serial two-wire spi done");
    {i_spi_en, i_tca_en} <= 2'h1;
    for (int c = 0; c < 7; c++)
    begin
      bus(1, 4, 8'(c), 4'h1);
      probe(c == 6 ? 7 : 5, c == 6 ? 0 : c * 8, 6, 0);
    end
    {i_tca_en, i_tcb_en} <= 5'h0f;
    for (int j = 0; j < 8; j++)
    begin
      bus(1, 5, j < 4 ? 8'h00 : 8'h0f, 4'h1);
      probe(6, j < 4 ? p0[j%4] : p1[j%4], 1, j % 4);
    end
    $display("test timers done");
    give_verdict();
  end
endmodule
